// ===== hw/supervisor_pkg.sv
// Purpose: constants and types for the supervisor reset / power-fail block
// Assumes: 200 MHz aclk; supply and sense comparators arrive as levels
// Notes:   every timing count derives from a time or a frequency in its own unit
package supervisor_pkg;

  // clock rate
  localparam int unsigned CLK_HZ = 200_000_000;

  // fast reset input: accept at 200 ns, reject below 50 ns
  localparam int unsigned FAST_ACCEPT_NS = 200;
  localparam int unsigned FAST_REJECT_NS = 50;
  localparam int unsigned FAST_ACCEPT_CYC =
    (FAST_ACCEPT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  // slow reset input: accept at 100 ms, reject below 20 ms
  localparam int unsigned SLOW_ACCEPT_MS = 100;
  localparam int unsigned SLOW_REJECT_MS = 20;
  localparam int unsigned SLOW_ACCEPT_CYC = SLOW_ACCEPT_MS * (CLK_HZ / 1000);

  // hold (deselect) times
  localparam int unsigned HOLD_STD_MIN_MS  = 96;
  localparam int unsigned HOLD_STD_MAX_MS  = 98;
  localparam int unsigned HOLD_HALT_MIN_MS = 40;
  localparam int unsigned HOLD_HALT_MAX_MS = 200;
  localparam int unsigned HOLD_SHORT_MIN_US = 50;
  localparam int unsigned HOLD_SHORT_MAX_US = 2000;
  localparam int unsigned HOLD_STD_CYC   = HOLD_STD_MIN_MS * (CLK_HZ / 1000);
  localparam int unsigned HOLD_HALT_CYC  = HOLD_HALT_MIN_MS * (CLK_HZ / 1000);
  localparam int unsigned HOLD_SHORT_CYC = HOLD_SHORT_MIN_US * (CLK_HZ / 1_000_000);

  // fixed clock output must run within four seconds of power-up
  localparam int unsigned FIXED_START_S = 4;
  // 32 kHz half period from the 200 MHz clock
  localparam int unsigned FIXED_HZ = 32_768;
  localparam int unsigned FIXED_HALF_CYC = CLK_HZ / (2 * FIXED_HZ);

  // battery check interval, 24 hours
  localparam int unsigned BATT_INTERVAL_H = 24;
  localparam longint unsigned BATT_INTERVAL_CYC =
    longint'(BATT_INTERVAL_H) * 64'd3600 * longint'(CLK_HZ);

  // register field positions
  localparam int unsigned CENTURY_EN_POS = 7;  // reg 03h
  localparam int unsigned CENTURY_BIT_POS = 6; // reg 03h
  localparam int unsigned OUT_LEVEL_POS = 7;   // reg 08h
  localparam int unsigned FREQ_TEST_POS = 6;   // reg 08h
  localparam int unsigned BATT_WEAK_POS = 4;   // reg 0Fh
  localparam int unsigned DESELECT_LEN_POS = 7; // reg 04h
  localparam int unsigned HALT_POS = 7;        // reg 01h

  // axi4-lite register map
  localparam logic [7:0] REG_CONTROL = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_WATCHDOG = 8'h08;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // reset values of control bits on first power application
  localparam logic RST_OUT_LEVEL = 1'b1;
  localparam logic RST_HALT_UPDATE = 1'b1;

  // supervisor states, one-hot
  typedef enum logic [3:0] {
    ST_BACKUP = 4'b0001,
    ST_HOLD   = 4'b0010,
    ST_RUN    = 4'b0100,
    ST_EXTRST = 4'b1000
  } sup_state_t;

endpackage : supervisor_pkg

// ===== hw/supervisor_reset_powerfail_ctl.sv
// Purpose: reset output, power-fail warning, fixed clock and power-on defaults
// Assumes: supply comparators and sense comparator are synchronous levels
// Notes:   registers reached over axi4-lite; long counts are parameters
// Operation
// - drive 32 kHz on fixed clock out when supply ok and not halted
// - fixed clock starts within four seconds; stops on halt or backup
// - reset out low at trip level, held for hold time on power-up
// - two external reset inputs each give a power-cycle-like reset
// - fast input accepted after 200 ns low, ignored under 50 ns
// - slow input accepted after 100 ms low while halt bit clear, ignored under 20 ms
// - reset released one hold time after accepted input returns high
// - warning output follows sense comparator while comparator enabled
// - in backup the comparator is off and warning is low
// - on power return warning forced high for hold time, then follows
// - century bit inverts at century turn when enable is set
// - general pin follows output-level bit when test, alarm, watchdog zero
// - battery checked at power-up and every 24 hours; weak sets flag
// - weak flag stays until a later check passes
// - battery checks only while main supply present
// - deselect length bit selects the hold time length
// - hold time per length bit and halt bit combination
// - bus writes refused during the deselect hold time
// - first power-up clears length, halt, test, alarm, square wave and watchdog; sets output level and halt-update
// - later power-up keeps length, halt, level, century enable; sets halt-update; clears test, alarm, square wave, watchdog
// - watchdog expiry with steer bit set pulses reset for hold time
`timescale 1ns/100ps
`default_nettype none
module supervisor_reset_powerfail_ctl
  import supervisor_pkg::*;
#(
  parameter int unsigned HOLD_STD  = supervisor_pkg::HOLD_STD_CYC,   // 96 ms
  parameter int unsigned HOLD_HALT = supervisor_pkg::HOLD_HALT_CYC,  // 40 ms
  parameter int unsigned HOLD_SHORT = supervisor_pkg::HOLD_SHORT_CYC, // 50 us
  parameter int unsigned SLOW_ACCEPT = supervisor_pkg::SLOW_ACCEPT_CYC, // 100 ms
  parameter longint unsigned BATT_INTERVAL = supervisor_pkg::BATT_INTERVAL_CYC
) (
  input  wire logic        aclk,            // system clock
  input  wire logic        aresetn,         // sync reset, active low
  input  wire logic        supply_ok,       // supply at or above trip level
  input  wire logic        supply_above_so, // supply at or above switch-over
  input  wire logic        first_power,     // no battery retained on power-up
  input  wire logic        fail_sense_in,   // sense comparator, high = above ref
  input  wire logic        fast_reset_in,   // external fast reset, active low
  input  wire logic        slow_reset_in,   // external slow reset, active low
  input  wire logic        watchdog_expire, // watchdog timeout pulse
  input  wire logic        century_turn,    // century rollover pulse
  input  wire logic        battery_low_in,  // battery comparator, high = weak
  input  wire logic        alarm_irq_enable, // alarm interrupt enable
  output logic             reset_out_n,     // processor reset, active low
  output logic             reset_out_oe,    // open drain enable
  output logic             fail_warn_n,     // power-fail warning, active low
  output logic             fixed_clock_out, // 32 kHz output
  output logic             irq_test_pin_oe, // open drain pin pulled low
  output logic             write_block,     // writes refused
  output logic             century_toggle_bit, // century bit
  output logic             battery_weak_flag, // battery weak
  // axi4-lite slave
  input  wire logic [7:0]  s_awaddr,        // write address
  input  wire logic        s_awvalid,       // write address valid
  output logic             s_awready,       // write address ready
  input  wire logic [31:0] s_wdata,         // write data
  input  wire logic [3:0]  s_wstrb,         // write strobes
  input  wire logic        s_wvalid,        // write data valid
  output logic             s_wready,        // write data ready
  output logic [1:0]       s_bresp,         // write response
  output logic             s_bvalid,        // write response valid
  input  wire logic        s_bready,        // write response ready
  input  wire logic [7:0]  s_araddr,        // read address
  input  wire logic        s_arvalid,       // read address valid
  output logic             s_arready,       // read address ready
  output logic [31:0]      s_rdata,         // read data
  output logic [1:0]       s_rresp,         // read response
  output logic             s_rvalid,        // read data valid
  input  wire logic        s_rready         // read data ready
);
  import supervisor_pkg::*;

  typedef struct packed {
    sup_state_t  st;
    logic [31:0] hold_cnt;
    logic [31:0] slow_cnt;
    logic [7:0]  fast_cnt;
    logic [1:0]  fast_sync;
    logic [1:0]  slow_sync;
    logic        fast_ok;
    logic        slow_ok;
    logic [15:0] fclk_div;
    logic        fclk;
    logic [63:0] batt_cnt;
    logic        batt_weak;
    logic        batt_pending;
    logic        century_en;
    logic        century_bit;
    logic        out_level;
    logic        freq_test;
    logic        deselect_len;
    logic        halt;
    logic        halt_update;
    logic        backup_alarm;
    logic        square_wave;
    logic [7:0]  watchdog;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } sup_t;

  sup_t cur;
  sup_t next_cur;

  // hold length per length bit and halt bit
  // length bit picks hold
  function automatic logic [31:0] hold_len(input logic len, input logic halt);
    if (len)
      return 32'(HOLD_SHORT);
    else if (halt)
      return 32'(HOLD_HALT);
    else
      return 32'(HOLD_STD);
  endfunction

  logic do_write;
  logic [31:0] wd;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_cur = cur;
    wd = cur.w_data;
    do_write = 1'b0;

    next_cur.fast_sync = {cur.fast_sync[0], fast_reset_in};
    next_cur.slow_sync = {cur.slow_sync[0], slow_reset_in};

    if (cur.fast_sync[1])
      next_cur.fast_cnt = 8'h00;
    else if (cur.fast_cnt < 8'(FAST_ACCEPT_CYC))
      next_cur.fast_cnt = cur.fast_cnt + 8'h01;
    next_cur.fast_ok = !cur.fast_sync[1] && cur.fast_cnt >= 8'(FAST_ACCEPT_CYC - 1);

    // slow low-width count, only with oscillator running
    if (cur.slow_sync[1] || cur.halt)
      next_cur.slow_cnt = 32'h0000_0000;
    else if (cur.slow_cnt < 32'(SLOW_ACCEPT))
      next_cur.slow_cnt = cur.slow_cnt + 32'h0000_0001;
    next_cur.slow_ok = !cur.slow_sync[1] && !cur.halt
                       && cur.slow_cnt >= 32'(SLOW_ACCEPT - 1);

    if (cur.fclk_div >= 16'(FIXED_HALF_CYC - 1)) begin
      next_cur.fclk_div = 16'h0000;
      next_cur.fclk = !cur.fclk;
    end else begin
      next_cur.fclk_div = cur.fclk_div + 16'h0001;
    end

    unique case (cur.st)
      ST_BACKUP: begin
        if (supply_ok) begin
          next_cur.st = ST_HOLD;
          next_cur.hold_cnt = 32'h0000_0000;
          next_cur.batt_pending = 1'b1;
          if (first_power) begin
            next_cur.deselect_len = 1'b0;
            next_cur.halt = 1'b0;
            next_cur.out_level = RST_OUT_LEVEL;
          end
          next_cur.halt_update = RST_HALT_UPDATE;
          next_cur.freq_test = 1'b0;
          next_cur.backup_alarm = 1'b0;
          next_cur.square_wave = 1'b0;
          next_cur.watchdog = 8'h00;
        end
      end
      ST_HOLD: begin
        if (cur.hold_cnt >= hold_len(cur.deselect_len, cur.halt) - 32'h0000_0001)
          next_cur.st = ST_RUN;
        else
          next_cur.hold_cnt = cur.hold_cnt + 32'h0000_0001;
      end
      ST_RUN: begin
        // external inputs act like a power cycle
        if (cur.fast_ok || cur.slow_ok)
          next_cur.st = ST_EXTRST;
        else if (watchdog_expire && cur.watchdog[7]) begin
          next_cur.st = ST_HOLD;
          next_cur.hold_cnt = 32'h0000_0000;
          next_cur.watchdog = 8'h00;
          next_cur.freq_test = 1'b0;
          next_cur.backup_alarm = 1'b0;
          next_cur.square_wave = 1'b0;
        end
      end
      ST_EXTRST: begin
        // hold counts from release of the input
        if (cur.fast_sync[1] && cur.slow_sync[1]) begin
          next_cur.st = ST_HOLD;
          next_cur.hold_cnt = 32'h0000_0000;
        end
      end
    endcase
    if (!supply_ok)
      next_cur.st = ST_BACKUP;

    if (cur.st != ST_BACKUP)
      next_cur.batt_cnt = (cur.batt_cnt >= BATT_INTERVAL - 64'd1) ? 64'd0
                          : cur.batt_cnt + 64'd1;
    if (cur.st != ST_BACKUP && (cur.batt_pending || cur.batt_cnt >= BATT_INTERVAL - 64'd1)) begin
      next_cur.batt_weak = battery_low_in;
      next_cur.batt_pending = 1'b0;
    end

    if (century_turn && cur.century_en)
      next_cur.century_bit = !cur.century_bit;

    // axi write channel
    if (s_awvalid && !cur.aw_got) begin
      next_cur.aw_got = 1'b1;
      next_cur.aw_addr = s_awaddr;
    end
    if (s_wvalid && !cur.w_got) begin
      next_cur.w_got = 1'b1;
      next_cur.w_data = s_wdata;
    end
    if (cur.aw_got && cur.w_got && !cur.bvalid) begin
      next_cur.aw_got = 1'b0;
      next_cur.w_got = 1'b0;
      next_cur.bvalid = 1'b1;
      next_cur.bresp = RESP_OKAY;
      // writes refused while held; a reset starting now beats the write
      if (cur.st != ST_RUN || next_cur.st != ST_RUN)
        next_cur.bresp = RESP_SLVERR;
      else if (cur.aw_addr == REG_CONTROL || cur.aw_addr == REG_WATCHDOG)
        do_write = s_wstrb == 4'hf || 1'b1;
      else if (cur.aw_addr != REG_STATUS)
        next_cur.bresp = RESP_SLVERR;
    end
    if (do_write && cur.aw_addr == REG_CONTROL) begin
      next_cur.century_en = wd[0];
      next_cur.out_level = wd[1];
      next_cur.freq_test = wd[2];
      next_cur.deselect_len = wd[3];
      next_cur.halt = wd[4];
      next_cur.halt_update = wd[5];
      next_cur.backup_alarm = wd[6];
      next_cur.square_wave = wd[7];
      if (!(century_turn && cur.century_en))
        next_cur.century_bit = wd[8];
    end
    if (do_write && cur.aw_addr == REG_WATCHDOG)
      next_cur.watchdog = wd[7:0];
    if (cur.bvalid && s_bready)
      next_cur.bvalid = 1'b0;

    // axi read channel
    if (s_arvalid && !cur.rvalid) begin
      next_cur.rvalid = 1'b1;
      next_cur.rresp = RESP_OKAY;
      next_cur.rdata = 32'h0000_0000;
      unique case (s_araddr)
        REG_CONTROL:  next_cur.rdata = {23'h0, cur.century_bit, cur.square_wave,
                        cur.backup_alarm, cur.halt_update, cur.halt,
                        cur.deselect_len, cur.freq_test, cur.out_level, cur.century_en};
        REG_STATUS:   next_cur.rdata = {28'h0, cur.st};
        REG_WATCHDOG: next_cur.rdata = {24'h0, cur.watchdog};
        default:      next_cur.rresp = RESP_SLVERR;
      endcase
      next_cur.rdata[8 + BATT_WEAK_POS] = (s_araddr == REG_STATUS) && cur.batt_weak;
    end else if (cur.rvalid && s_rready) begin
      next_cur.rvalid = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; aresetn clears all state, then loads backup state, output level, halt-update and all-ones input synchronisers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur <= '0;
      cur.st <= ST_BACKUP;
      cur.out_level <= RST_OUT_LEVEL;
      cur.halt_update <= RST_HALT_UPDATE;
      cur.fast_sync <= 2'b11;
      cur.slow_sync <= 2'b11;
    end else begin
      cur <= next_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  // reset low outside run
  assign reset_out_n = (cur.st == ST_RUN);
  assign reset_out_oe = !reset_out_n;
  // warning follows comparator in run; low in backup; high in hold
  assign fail_warn_n = (cur.st == ST_RUN) ? fail_sense_in : (cur.st != ST_BACKUP);
  assign fixed_clock_out = cur.fclk && supply_above_so && !cur.halt && (cur.st != ST_BACKUP);
  // general pin drives the level bit
  assign irq_test_pin_oe = !cur.freq_test && !alarm_irq_enable && (cur.watchdog == 8'h00)
                           && !cur.out_level;
  assign write_block = (cur.st != ST_RUN);
  assign century_toggle_bit = cur.century_bit;
  assign battery_weak_flag = cur.batt_weak;
  assign s_awready = !cur.aw_got;
  assign s_wready = !cur.w_got;
  assign s_bvalid = cur.bvalid;
  assign s_bresp = cur.bresp;
  assign s_arready = !cur.rvalid;
  assign s_rvalid = cur.rvalid;
  assign s_rdata = cur.rdata;
  assign s_rresp = cur.rresp;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  backup_reset_a : assert property (@(posedge aclk) disable iff (!aresetn)
    !supply_ok |=> !reset_out_n) else $error("reset not low after supply loss");
  backup_warn_a : assert property (@(posedge aclk) disable iff (!aresetn)
    cur.st == ST_BACKUP |-> !fail_warn_n) else $error("warning high in backup");
  hold_warn_a : assert property (@(posedge aclk) disable iff (!aresetn)
    cur.st == ST_HOLD |-> fail_warn_n && !reset_out_n) else $error("hold outputs wrong");
  run_warn_a : assert property (@(posedge aclk) disable iff (!aresetn)
    cur.st == ST_RUN |-> fail_warn_n == fail_sense_in) else $error("warning not following");
  fixed_halt_a : assert property (@(posedge aclk) disable iff (!aresetn)
    cur.halt |-> !fixed_clock_out) else $error("fixed clock while halted");
  write_block_a : assert property (@(posedge aclk) disable iff (!aresetn)
    cur.aw_got && cur.w_got && !cur.bvalid && cur.st != ST_RUN |=> s_bresp == RESP_SLVERR)
    else $error("write accepted during hold");
  fast_glitch_a : assert property (@(posedge aclk) disable iff (!aresetn)
    cur.fast_sync[1] ##1 !cur.fast_sync[1] [*8] |=> !cur.fast_ok)
    else $error("short fast pulse accepted");
  century_flip_a : assert property (@(posedge aclk) disable iff (!aresetn)
    century_turn && cur.century_en && !do_write |=> cur.century_bit != $past(cur.century_bit))
    else $error("century bit did not toggle");
  pin_level_a : assert property (@(posedge aclk) disable iff (!aresetn)
    !cur.freq_test && !alarm_irq_enable && cur.watchdog == 8'h00 && cur.out_level
    |-> !irq_test_pin_oe) else $error("pin driven with level high");
  wd_pulse_a : assert property (@(posedge aclk) disable iff (!aresetn)
    cur.st == ST_RUN && supply_ok && !cur.fast_ok && !cur.slow_ok && watchdog_expire
    && cur.watchdog[7] |=> !reset_out_n) else $error("watchdog reset missing");
  slow_glitch_a : assert property (@(posedge aclk) disable iff (!aresetn)
    cur.slow_sync[1] ##1 !cur.slow_sync[1] [*8] |=> !cur.slow_ok)
    else $error("short slow pulse accepted");
  batt_backup_a : assert property (@(posedge aclk) disable iff (!aresetn)
    cur.st == ST_BACKUP |=> $stable(battery_weak_flag))
    else $error("battery checked in backup");
  century_keep_a : assert property (@(posedge aclk) disable iff (!aresetn)
    century_turn && !cur.century_en && !do_write |=> $stable(century_toggle_bit))
    else $error("century bit toggled while disabled");
  write_refuse_a : assert property (@(posedge aclk) disable iff (!aresetn)
    cur.st != ST_RUN |-> !do_write)
    else $error("write landed outside run");
  fixed_run_a : assert property (@(posedge aclk) disable iff (!aresetn)
    cur.st != ST_BACKUP && supply_above_so && !cur.halt |-> fixed_clock_out == cur.fclk)
    else $error("fixed clock not running");

endmodule : supervisor_reset_powerfail_ctl
`default_nettype wire

// ===== bench/host_model.sv
// Purpose: host side of the open-drain reset line
// Assumes: the board pulls the reset line up
// Notes:   only watches; reports the last low run in cycles
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input  wire logic aclk,     // system clock
  input  wire logic rst_oe,   // device pulls reset low
  output logic      rst_line, // resolved reset wire
  output int        low_len   // length of last low run
);
  int run = 0;
  ////////////////////////////////////////////////////////////////
  // pull-up on reset
  // released line goes high, never keeps a stale low
  assign rst_line = rst_oe ? 1'h0 : 1'h1;
  always_ff @(posedge aclk) begin
    if (!rst_line) begin
      run <= run + 1;
    end else if (run != 0) begin
      low_len <= run;
      run <= 0;
    end
  end
endmodule // host_model
`default_nettype wire

// ===== bench/supervisor_reset_powerfail_ctl_test.sv
// Purpose: self-checking bench for the supervisor block
// Assumes: hold and slow-input counts shortened by parameter
// Notes:   bus sampled on falling edge so ready never races
`timescale 1ns/100ps
`default_nettype none
module supervisor_reset_powerfail_ctl_test;
  import supervisor_pkg::*;
  localparam int HS = 20;       // standard hold
  localparam int HQ = 5;        // short hold
  localparam int LIMIT = 40000; // hang ceiling
  logic aclk, aresetn, supply_ok, supply_above_so, first_power, fail_sense_in;
  logic fast_reset_in, slow_reset_in, watchdog_expire, century_turn, rst_line;
  logic battery_low_in, alarm_irq_enable, reset_out_n, reset_out_oe, fail_warn_n;
  logic fixed_clock_out, irq_test_pin_oe, write_block, century_toggle_bit;
  logic battery_weak_flag, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid;
  logic s_bready, s_arvalid, s_arready, s_rvalid, s_rready;
  logic [7:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp, rsp;
  int cyc = 0, checks = 0, bad_count = 0, low_len, n, t0;
  supervisor_reset_powerfail_ctl #(.HOLD_STD(HS), .HOLD_HALT(10), .HOLD_SHORT(HQ),
    .SLOW_ACCEPT(100), .BATT_INTERVAL(200)) dut (
    .aclk, .aresetn, .supply_ok, .supply_above_so, .first_power, .fail_sense_in,
    .fast_reset_in, .slow_reset_in, .watchdog_expire, .century_turn, .battery_low_in,
    .alarm_irq_enable, .reset_out_n, .reset_out_oe, .fail_warn_n, .fixed_clock_out,
    .irq_test_pin_oe, .write_block, .century_toggle_bit, .battery_weak_flag,
    .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready,
    .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
    .s_rresp, .s_rvalid, .s_rready);
  host_model host (.aclk, .rst_oe(reset_out_oe), .rst_line, .low_len);
  ////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    aclk = 1'h0;
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string w, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", w, e, g);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  // bus tasks: hold each channel until its own ready is seen
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic taw, tw, tb;
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'h1;
    s_wvalid <= 1'h1;
    s_bready <= 1'h1;
    do begin
      @(negedge aclk);
      taw = s_awvalid && s_awready;
      tw = s_wvalid && s_wready;
      tb = s_bvalid;
      rsp = s_bresp;
      @(posedge aclk);
      if (taw) s_awvalid <= 1'h0;
      if (tw) s_wvalid <= 1'h0;
    end while (!tb);
    s_bready <= 1'h0;
    // response only after address and data were both taken
    chk("write order", 32'h0, {s_awvalid, s_wvalid});
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] er);
    logic tar, tr;
    logic [31:0] d;
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'h1;
    s_rready <= 1'h1;
    do begin
      @(negedge aclk);
      tar = s_arvalid && s_arready;
      tr = s_rvalid;
      d = s_rdata;
      rsp = s_rresp;
      @(posedge aclk);
      if (tar) s_arvalid <= 1'h0;
    end while (!tr);
    s_rready <= 1'h0;
    chk("read resp", er, rsp);
    chk("read data", e, d & m);
    chk("read order", 32'h0, s_arvalid);
  endtask
  task automatic wait_rst(input logic lv);
    repeat (3000) begin
      @(negedge aclk);
      if (reset_out_n === lv) return;
    end
    chk("reset level", lv, reset_out_n);
  endtask
  task automatic togs(input int c, output int tg);
    logic p;
    tg = 0;
    p = fixed_clock_out;
    repeat (c) begin
      @(negedge aclk);
      tg += int'(fixed_clock_out !== p);
      p = fixed_clock_out;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_power();
    @(negedge aclk);
    chk("reset in backup", 1'h0, reset_out_n);
    chk("clock in backup", 1'h0, fixed_clock_out);
    @(posedge aclk);
    supply_ok <= 1'h1;
    supply_above_so <= 1'h1;
    t0 = cyc;
    wr(8'h00, 32'h0000_0000);
    chk("write in hold", RESP_SLVERR, rsp);
    chk("write block", 1'h1, write_block);
    chk("warn in hold", 1'h1, fail_warn_n);
    chk("reset in hold", 1'h0, reset_out_n);
    wait_rst(1'h1);
    n = cyc - t0;
    chk("hold length", 1'h1, n >= HS && n <= HS + 4);
    chk("warn follows low", 1'h0, fail_warn_n);
    chk("battery at power-up", 1'h1, battery_weak_flag);
    rchk(8'h00, 32'h0000_01ff, 32'h0000_0022, RESP_OKAY);
    fail_sense_in <= 1'h1;
    battery_low_in <= 1'h0;
    repeat (210) @(negedge aclk);
    chk("warn follows high", 1'h1, fail_warn_n);
    chk("battery recheck", 1'h0, battery_weak_flag);
  endtask
  task automatic t_ext(input logic slow, input int len, input logic acc);
    logic low;
    low = 1'h0;
    @(posedge aclk);
    if (slow) slow_reset_in <= 1'h0;
    else fast_reset_in <= 1'h0;
    repeat (len) @(posedge aclk);
    slow_reset_in <= 1'h1;
    fast_reset_in <= 1'h1;
    t0 = cyc;
    repeat (5) begin
      @(negedge aclk);
      low |= !reset_out_n;
    end
    chk("input taken", acc, low);
    if (acc) begin
      wait_rst(1'h1);
      n = cyc - t0;
      chk("release delay", 1'h1, n >= HS && n <= HS + 5);
    end
  endtask
  task automatic t_misc();
    logic c0;
    for (int e = 1; e >= 0; e--) begin
      c0 = century_toggle_bit;
      wr(8'h00, {23'h0, c0, 6'h0, 1'h1, e[0]});
      century_turn <= 1'h1;
      @(posedge aclk);
      century_turn <= 1'h0;
      repeat (3) @(negedge aclk);
      chk("century bit", c0 ^ e[0], century_toggle_bit);
    end
    wr(8'h00, 32'h0000_0000);
    chk("pin at level 0", 1'h1, irq_test_pin_oe);
    alarm_irq_enable <= 1'h1;
    repeat (2) @(negedge aclk);
    chk("pin with alarm", 1'h0, irq_test_pin_oe);
    @(posedge aclk);
    alarm_irq_enable <= 1'h0;
    wr(8'h00, 32'h0000_0004);
    chk("pin with test", 1'h0, irq_test_pin_oe);
    wr(8'h08, 32'h0000_0080);
    watchdog_expire <= 1'h1;
    @(posedge aclk);
    watchdog_expire <= 1'h0;
    wait_rst(1'h0);
    wait_rst(1'h1);
    repeat (2) @(negedge aclk);
    chk("watchdog pulse", 1'h1, low_len >= HS && low_len <= HS + 3);
    wr(8'h00, 32'h0000_0002);
    togs(4 * FIXED_HALF_CYC, n);
    chk("clock running", 1'h1, n >= 3 && n <= 5);
    wr(8'h00, 32'h0000_0012);
    togs(2 * FIXED_HALF_CYC, n);
    chk("clock halted", 1'h1, n <= 1);
  endtask
  task automatic t_backup();
    wr(8'h00, 32'h0000_000c);
    wr(8'h08, 32'h0000_0001);
    supply_ok <= 1'h0;
    supply_above_so <= 1'h0;
    first_power <= 1'h0;
    battery_low_in <= 1'h1;
    repeat (3) @(negedge aclk);
    chk("reset at trip", 1'h0, reset_out_n);
    chk("warn in backup", 1'h0, fail_warn_n);
    // stay down longer than one check interval
    repeat (210) @(negedge aclk);
    chk("no check in backup", 1'h0, battery_weak_flag);
    @(posedge aclk);
    supply_ok <= 1'h1;
    supply_above_so <= 1'h1;
    t0 = cyc;
    wait_rst(1'h1);
    n = cyc - t0;
    chk("short hold", 1'h1, n >= HQ && n <= HQ + 4);
    rchk(8'h04, 32'h0000_100f, 32'h0000_1004, RESP_OKAY);
    rchk(8'h00, 32'h0000_003e, 32'h0000_0028, RESP_OKAY);
    rchk(8'h08, 32'hffff_ffff, 32'h0000_0000, RESP_OKAY);
    rchk(8'h0c, 32'hffff_ffff, 32'h0000_0000, RESP_SLVERR);
    // halted oscillator with length bit clear picks the halt hold
    wr(8'h00, 32'h0000_0010);
    supply_ok <= 1'h0;
    repeat (3) @(negedge aclk);
    @(posedge aclk);
    supply_ok <= 1'h1;
    t0 = cyc;
    wait_rst(1'h1);
    n = cyc - t0;
    chk("halted hold", 1'h1, n >= 10 && n <= 14);
  endtask
  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {aresetn, supply_ok, supply_above_so, fail_sense_in, watchdog_expire} = '0;
    {century_turn, alarm_irq_enable, s_awvalid, s_wvalid, s_bready} = '0;
    {s_arvalid, s_rready, s_awaddr, s_araddr, s_wdata} = '0;
    {first_power, battery_low_in, fast_reset_in, slow_reset_in} = '1;
    s_wstrb = 4'hf;
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    t_power();
    t_ext(1'h0, 9, 1'h0);
    t_ext(1'h0, 60, 1'h1);
    t_ext(1'h1, 10, 1'h0);
    t_ext(1'h1, 150, 1'h1);
    t_misc();
    t_backup();
    give_verdict();
  end
endmodule // supervisor_reset_powerfail_ctl_test
`default_nettype wire
